//--- rbps_pkg.sv
// Package: constants and carrier types for the reset and boot-path selector
package rbps_pkg;

    // ----------------------------------------------------------------
    // Addresses and widths
    // ----------------------------------------------------------------
    localparam int          PC_W          = 16;
    localparam logic [15:0] START_ADDR    = 16'h8000;
    localparam logic [15:0] PWD_FIRST     = 16'h0010;
    localparam logic [15:0] PWD_LAST      = 16'h001F;
    localparam int          PWD_WORDS     = 16;

    // ----------------------------------------------------------------
    // TAP instruction register
    // ----------------------------------------------------------------
    localparam int          IR_W          = 4;
    localparam logic [3:0]  IR_RESET_VAL  = 4'h1;
    localparam logic [3:0]  IR_SYSPROG    = 4'h4;
    localparam logic [3:0]  IR_BOOTCTL    = 4'h5;
    localparam logic [3:0]  IR_BYPASS     = 4'hF;
    localparam int          DR_W          = 8;
    // Boot control data register field positions
    localparam int          DR_BOOTREQ_B  = 0;
    localparam int          DR_LOCK_B     = 1;
    localparam int          DR_INRST_B    = 2;
    localparam int          DR_UNLOCK_B   = 3;

    // ----------------------------------------------------------------
    // Loader operations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_LOAD   = 3'h1,
        OP_DUMP   = 3'h2,
        OP_CRC    = 3'h3,
        OP_VERIFY = 3'h4,
        OP_ERASE  = 3'h5
    } rbps_op_e;

    typedef enum logic [3:0] {
        TS_RESET  = 4'h0, TS_IDLE   = 4'h1, TS_SELDR  = 4'h2, TS_CAPDR  = 4'h3,
        TS_SHDR   = 4'h4, TS_EX1DR  = 4'h5, TS_PADR   = 4'h6, TS_EX2DR  = 4'h7,
        TS_UPDR   = 4'h8, TS_SELIR  = 4'h9, TS_CAPIR  = 4'hA, TS_SHIR   = 4'hB,
        TS_EX1IR  = 4'hC, TS_PAIR   = 4'hD, TS_EX2IR  = 4'hE, TS_UPIR   = 4'hF
    } rbps_tap_e;

    typedef enum logic [1:0] {
        BS_RESET  = 2'h0,
        BS_LOADER = 2'h1,
        BS_APP    = 2'h2
    } rbps_boot_e;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } rbps_jtag_s;

    typedef struct packed {
        logic           req;
        rbps_op_e       op;
        logic [15:0]    addr;
        logic [15:0]    wdata;
    } rbps_mem_req_s;

    typedef struct packed {
        logic           fetch_load;
        logic [15:0]    fetch_addr;
        logic           loader_run;
        logic           app_run;
    } rbps_core_s;

endpackage : rbps_pkg

//--- rbps_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module rbps_sync
    import rbps_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output      logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : rbps_sync

//--- rbps_top.sv
// Reset and boot-path selector with TAP, lock and loader operation port
`timescale 1ns/100ps
module rbps_top
    import rbps_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          por_n,
    input  wire logic          ext_reset_n,
    input  rbps_jtag_s         jtag_in,
    output      logic          tdo,
    output      logic          tdo_oe,
    output      rbps_core_s    core,
    output      logic          core_reset_n,
    input  wire logic          loader_clear_req,
    input  wire logic          loader_soft_reset,
    input  wire logic          pwd_match,
    input  wire logic          iap_req,
    input  rbps_mem_req_s      loader_req,
    output      rbps_mem_req_s flash_req,
    output      logic          access_denied,
    output      logic          lock_flag
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic       rst_pin_n;
    rbps_jtag_s jtag;

    rbps_sync #(.W(4)) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({ext_reset_n, jtag_in}),
        .q     ({rst_pin_n, jtag})
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic               tck_d;
        rbps_tap_e          tap;
        logic [IR_W-1:0]    ir_sh;
        logic [IR_W-1:0]    ir;
        logic [DR_W-1:0]    dr_sh;
        logic               boot_req;
        logic               lock;
        logic               unlocked;
        logic               sysprog;
        logic               in_reset;
        rbps_boot_e         boot;
        logic               tdo;
        logic               tdo_oe;
        rbps_core_s         core;
        logic               core_rst_n;
        rbps_mem_req_s      flash;
        logic               denied;
    } rbps_state_s;

    rbps_state_s s_r;
    rbps_state_s s_nxt;

    logic tck_rise;
    logic tck_fall;
    logic hold_reset;
    logic pwd_area;
    logic gate_open;

    assign tck_rise   = jtag.tck & ~s_r.tck_d;
    assign tck_fall   = ~jtag.tck & s_r.tck_d;
    assign hold_reset = ~rst_pin_n | loader_soft_reset;
    assign pwd_area   = (loader_req.addr >= PWD_FIRST) && (loader_req.addr <= PWD_LAST);
    assign gate_open  = ~s_r.lock | s_r.unlocked;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.tck_d = jtag.tck;
        s_nxt.core.fetch_load = 1'b0;
        s_nxt.flash.req = 1'b0;
        s_nxt.denied = 1'b0;

        // TAP keeps running in every core state, including reset
        if (tck_rise) begin
            case (s_r.tap)
                TS_RESET: s_nxt.tap = jtag.tms ? TS_RESET : TS_IDLE;
                TS_IDLE:  s_nxt.tap = jtag.tms ? TS_SELDR : TS_IDLE;
                TS_SELDR: s_nxt.tap = jtag.tms ? TS_SELIR : TS_CAPDR;
                TS_CAPDR: s_nxt.tap = jtag.tms ? TS_EX1DR : TS_SHDR;
                TS_SHDR:  s_nxt.tap = jtag.tms ? TS_EX1DR : TS_SHDR;
                TS_EX1DR: s_nxt.tap = jtag.tms ? TS_UPDR  : TS_PADR;
                TS_PADR:  s_nxt.tap = jtag.tms ? TS_EX2DR : TS_PADR;
                TS_EX2DR: s_nxt.tap = jtag.tms ? TS_UPDR  : TS_SHDR;
                TS_UPDR:  s_nxt.tap = jtag.tms ? TS_SELDR : TS_IDLE;
                TS_SELIR: s_nxt.tap = jtag.tms ? TS_RESET : TS_CAPIR;
                TS_CAPIR: s_nxt.tap = jtag.tms ? TS_EX1IR : TS_SHIR;
                TS_SHIR:  s_nxt.tap = jtag.tms ? TS_EX1IR : TS_SHIR;
                TS_EX1IR: s_nxt.tap = jtag.tms ? TS_UPIR  : TS_PAIR;
                TS_PAIR:  s_nxt.tap = jtag.tms ? TS_EX2IR : TS_PAIR;
                TS_EX2IR: s_nxt.tap = jtag.tms ? TS_UPIR  : TS_SHIR;
                TS_UPIR:  s_nxt.tap = jtag.tms ? TS_SELDR : TS_IDLE;
                default:  s_nxt.tap = TS_RESET;
            endcase
            case (s_r.tap)
                TS_RESET: s_nxt.ir = IR_RESET_VAL;
                TS_CAPIR: s_nxt.ir_sh = IR_RESET_VAL;
                TS_SHIR:  s_nxt.ir_sh = {jtag.tdi, s_r.ir_sh[IR_W-1:1]};
                TS_CAPDR: s_nxt.dr_sh = (s_r.ir == IR_BOOTCTL)
                                        ? {4'h0, s_r.unlocked, s_r.in_reset, s_r.lock, s_r.boot_req}
                                        : '0;
                TS_SHDR:  s_nxt.dr_sh = {jtag.tdi, s_r.dr_sh[DR_W-1:1]};
                TS_UPIR: begin
                    s_nxt.ir = s_r.ir_sh;
                    s_nxt.sysprog = (s_r.ir_sh == IR_SYSPROG);
                end
                TS_UPDR: begin
                    // Request bit only accepted while the core is in reset
                    if (s_r.ir == IR_BOOTCTL && s_r.in_reset) begin
                        s_nxt.boot_req = s_r.dr_sh[DR_BOOTREQ_B];
                    end
                end
                default: begin
                end
            endcase
        end

        // TDO changes on falling edge, driven only while shifting
        if (tck_fall) begin
            s_nxt.tdo_oe = (s_r.tap == TS_SHDR) || (s_r.tap == TS_SHIR);
            s_nxt.tdo = (s_r.tap == TS_SHIR) ? s_r.ir_sh[0] : s_r.dr_sh[0];
        end

        // System-programming instruction requests loader boot
        if (s_r.sysprog && s_r.in_reset) begin
            s_nxt.boot_req = 1'b1;
        end

        // Loader clears the request bit; the system-programming set wins in same cycle
        if (loader_clear_req && !(s_r.sysprog && s_r.in_reset)) begin
            s_nxt.boot_req = 1'b0;
        end

        // Unlock by matching password, relock on pin or soft reset
        if (pwd_match) begin
            s_nxt.unlocked = 1'b1;
        end

        // Reset entry and boot path selection
        case (s_r.boot)
            BS_RESET: begin
                s_nxt.core_rst_n = 1'b0;
                s_nxt.core.loader_run = 1'b0;
                s_nxt.core.app_run = 1'b0;
                if (!hold_reset) begin
                    s_nxt.in_reset = 1'b0;
                    s_nxt.core_rst_n = 1'b1;
                    s_nxt.core.fetch_load = 1'b1;
                    s_nxt.core.fetch_addr = START_ADDR;
                    // Sampled at release decides the path
                    s_nxt.boot = s_r.boot_req ? BS_LOADER : BS_APP;
                    s_nxt.core.loader_run = s_r.boot_req;
                    s_nxt.core.app_run = ~s_r.boot_req;
                end
            end
            BS_LOADER, BS_APP: begin
                if (hold_reset) begin
                    s_nxt.boot = BS_RESET;
                    s_nxt.in_reset = 1'b1;
                    s_nxt.core_rst_n = 1'b0;
                    s_nxt.unlocked = 1'b0;
                    s_nxt.sysprog = 1'b0;
                    s_nxt.core.loader_run = 1'b0;
                    s_nxt.core.app_run = 1'b0;
                end
            end
            default: s_nxt.boot = BS_RESET;
        endcase

        // Flash port: loader ops or in-application access while app runs
        if (loader_req.req && loader_req.op != OP_NONE
            && (s_r.boot == BS_LOADER || (iap_req && s_r.boot == BS_APP))) begin
            // While locked, only a verify of the password words is let through
            if (gate_open || (pwd_area && loader_req.op == OP_VERIFY)) begin
                s_nxt.flash = loader_req;
            end else begin
                s_nxt.denied = 1'b1;
            end
        end

        // Lock only returns at power-on or on rst_n, not on pin or soft reset
        if (!por_n) begin
            s_nxt.lock = 1'b1;
            s_nxt.boot_req = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.tap <= TS_RESET;
            s_r.ir <= IR_RESET_VAL;
            s_r.in_reset <= 1'b1;
            s_r.boot <= BS_RESET;
            s_r.lock <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tdo           = s_r.tdo;
    assign tdo_oe        = s_r.tdo_oe;
    assign core          = s_r.core;
    assign core_reset_n  = s_r.core_rst_n;
    assign flash_req     = s_r.flash;
    assign access_denied = s_r.denied;
    assign lock_flag     = s_r.lock;

endmodule : rbps_top

//--- rbps_jtag_host.sv
// JTAG host model that drives the test access port pins
`timescale 1ns/100ps
module rbps_jtag_host
    import rbps_pkg::*;
(
    output rbps_jtag_s jtag,
    input  wire logic  tdo
);
    logic [7:0] cap;
    logic       smp;
    initial jtag = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
    // Host samples tdo on the rising edge, well after the device updates it
    task automatic bit_io(input logic ms, input logic di);
        jtag.tms = ms;
        jtag.tdi = di;
        #100 jtag.tck = 1'b1;
        smp = tdo;
        #60 jtag.tck = 1'b0;
    endtask : bit_io
    task automatic reset_tap;
        #7;
        repeat (5) bit_io(1'b1, 1'b0);
        bit_io(1'b0, 1'b0);
        jtag.tdi = 1'b1;
    endtask : reset_tap
    // Tck parks low between frames; tdi flips so a stale bit is never reused
    task automatic shift(input logic ir, input int n, input logic [7:0] v);
        #7;
        bit_io(1'b1, 1'b0);
        if (ir) bit_io(1'b1, 1'b0);
        bit_io(1'b0, 1'b0);
        bit_io(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            bit_io(i == n - 1, v[i]);
            cap = {smp, cap[7:1]};
        end
        bit_io(1'b1, 1'b0);
        bit_io(1'b0, 1'b0);
        jtag.tdi = ~jtag.tdi;
    endtask : shift
endmodule : rbps_jtag_host

//--- rbps_top_checker.sv
// Concurrent checks on the reset and boot-path selector ports
`timescale 1ns/100ps
module rbps_top_checker
    import rbps_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    rst_n,
    input  wire logic    por_n,
    input  wire logic    ext_reset_n,
    input  wire logic    iap_req,
    input  rbps_core_s    core,
    input  wire logic    core_reset_n,
    input  rbps_mem_req_s loader_req,
    input  rbps_mem_req_s flash_req,
    input  wire logic    access_denied,
    input  wire logic    lock_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Four cycles cover the pin synchroniser plus the output register
    hold_reset_a: assert property (!ext_reset_n [*4] |-> !core_reset_n)
        else $error("core out of reset while reset pin low");
    fetch_addr_a: assert property (core.fetch_load |-> core.fetch_addr == START_ADDR)
        else $error("fetch start address wrong");
    fetch_release_a: assert property ($rose(core_reset_n) |-> ##[0:1] core.fetch_load)
        else $error("no fetch load at reset release");
    boot_chosen_a: assert property ($rose(core_reset_n) |-> ##[0:2] (core.loader_run ^ core.app_run))
        else $error("no single boot path after release");
    lock_por_a: assert property (!por_n |=> lock_flag)
        else $error("lock not set by power-on");
    grant_copy_a: assert property (flash_req.req |-> $past(loader_req.req) && flash_req.op == $past(loader_req.op)
        && flash_req.addr == $past(loader_req.addr))
        else $error("granted request differs from the one taken");
    grant_deny_a: assert property (!(flash_req.req && access_denied))
        else $error("grant and denial together");
    deny_cause_a: assert property (access_denied |-> $past(lock_flag) && $past(loader_req.req))
        else $error("denial without lock or request");
    pwd_verify_a: assert property (loader_req.req && loader_req.op == OP_VERIFY && loader_req.addr inside
        {[PWD_FIRST:PWD_LAST]} && (core.loader_run || iap_req && core.app_run) |=> flash_req.req)
        else $error("password verify refused");
    cover property (core.fetch_load ##[0:2] core.loader_run);
    cover property (access_denied);
    cover property (flash_req.req && core.app_run);
endmodule : rbps_top_checker
bind rbps_top rbps_top_checker chk_i (.clock, .rst_n, .por_n, .ext_reset_n, .iap_req, .core, .core_reset_n,
    .loader_req, .flash_req, .access_denied, .lock_flag);

//--- rbps_top_test.sv
// Self-checking testbench for the reset and boot-path selector
`timescale 1ns/100ps
module rbps_top_test
    import rbps_pkg::*;
;
    logic          clock = 1'b0, rst_n = 1'b0, por_n = 1'b0, ext_reset_n = 1'b1;
    logic          loader_clear_req = 1'b0, loader_soft_reset = 1'b0, pwd_match = 1'b0, iap_req = 1'b0;
    rbps_mem_req_s loader_req = '0, flash_req;
    rbps_core_s    core;
    rbps_jtag_s    jtag_in;
    logic          tdo, tdo_oe, core_reset_n, access_denied, lock_flag;
    int            err_count = 0, n_checks = 0, cyc = 0, oe_seen = 0;
    rbps_top uut (.clock, .rst_n, .por_n, .ext_reset_n, .jtag_in, .tdo, .tdo_oe, .core, .core_reset_n,
        .loader_clear_req, .loader_soft_reset, .pwd_match, .iap_req, .loader_req, .flash_req, .access_denied,
        .lock_flag);
    rbps_jtag_host host (.jtag(jtag_in), .tdo(tdo));
    initial forever #10 clock = ~clock;
    // Counts cycles with the serial output driven, so a dead enable is caught
    always @(posedge clock) if (tdo_oe === 1'b1) oe_seen <= oe_seen + 1;
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic fop(input rbps_op_e op, input logic [15:0] a, input logic ok);
        @(posedge clock);
        loader_req <= '{1'b1, op, a, 16'hA5A5};
        @(posedge clock);
        loader_req.req <= 1'b0;
        #1;
        chk("flash_grant", 16'(ok), 16'(flash_req.req));
        chk("flash_deny", 16'(!ok), 16'(access_denied));
        if (ok) chk("flash_addr", a, flash_req.addr);
    endtask : fop
    task automatic boot(input logic ldr);
        for (int i = 0; i < 40 && core.fetch_load !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("fetch_load", 16'h0001, 16'(core.fetch_load));
        chk("fetch_addr", START_ADDR, core.fetch_addr);
        chk("core_reset_n", 16'h0001, 16'(core_reset_n));
        repeat (2) @(posedge clock);
        #1;
        chk("loader_run", 16'(ldr), 16'(core.loader_run));
        chk("app_run", 16'(!ldr), 16'(core.app_run));
    endtask : boot
    task automatic pin_reset;
        @(posedge clock);
        ext_reset_n <= 1'b0;
        repeat (6) @(posedge clock);
        #1 chk("held_reset", 16'h0000, 16'(core_reset_n));
        host.reset_tap();
    endtask : pin_reset
    task automatic t_loader;
        pin_reset();
        host.shift(1'b1, 4, 8'(IR_BOOTCTL));
        host.shift(1'b0, 8, 8'h01);
        chk("capture", 16'h0006, 16'(host.cap));
        chk("tdo_oe_shift", 16'h0001, 16'(oe_seen != 0));
        @(posedge clock);
        ext_reset_n <= 1'b1;
        boot(1'b1);
        chk("tdo_oe_idle", 16'h0000, 16'(tdo_oe));
    endtask : t_loader
    task automatic unlock;
        @(posedge clock);
        pwd_match <= 1'b1;
        @(posedge clock);
        pwd_match <= 1'b0;
    endtask : unlock
    task automatic t_lock;
        for (int o = 1; o <= 5; o++) fop(rbps_op_e'(o), 16'h0100, 1'b0);
        fop(OP_VERIFY, PWD_FIRST, 1'b1);
        fop(OP_VERIFY, PWD_LAST, 1'b1);
        fop(OP_VERIFY, PWD_LAST + 16'h0001, 1'b0);
        unlock();
        for (int o = 1; o <= 5; o++) fop(rbps_op_e'(o), 16'h0100, 1'b1);
    endtask : t_lock
    task automatic t_app;
        @(posedge clock);
        loader_clear_req <= 1'b1;
        @(posedge clock);
        loader_clear_req  <= 1'b0;
        loader_soft_reset <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk("soft_reset", 16'h0000, 16'(core_reset_n));
        @(posedge clock);
        loader_soft_reset <= 1'b0;
        boot(1'b0);
        @(posedge clock);
        iap_req <= 1'b1;
        fop(OP_ERASE, 16'h0200, 1'b0);
        fop(OP_VERIFY, PWD_FIRST, 1'b1);
        unlock();
        fop(OP_ERASE, 16'h0200, 1'b1);
        fop(OP_LOAD, 16'h0204, 1'b1);
        @(posedge clock);
        iap_req <= 1'b0;
        // Request write while running must be ignored; next capture shows it
        host.shift(1'b1, 4, 8'(IR_BOOTCTL));
        host.shift(1'b0, 8, 8'h01);
        host.shift(1'b0, 8, 8'h00);
        chk("run_refuse", 16'h000A, 16'(host.cap));
    endtask : t_app
    task automatic t_sysprog;
        pin_reset();
        host.shift(1'b1, 4, 8'(IR_SYSPROG));
        @(posedge clock);
        ext_reset_n <= 1'b1;
        boot(1'b1);
    endtask : t_sysprog
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        por_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk("lock_flag", 16'h0001, 16'(lock_flag));
        t_loader();
        t_lock();
        t_app();
        t_sysprog();
        summarize();
    end
endmodule : rbps_top_test
